// ---- core/hpp_pkg.sv ----
// Package with constants and register map for the hub port power and upstream sense block.
// Functional notes
// R1: Enabled port releases its power pin, pull-up on, switching port power on.
// R2: Low level on an enabled port's power pin means overcurrent on that port.
// R3: Disabled port, by configuration or host, drives its power pin low; shared mode drives only the shared pin, with both ports disabled.
// R4: Names ending in the low-active suffix assert low, all others assert high.
// R5: Upstream power sense input decides whether the upstream connection is up.
// R6: Toggling upstream sense drops and re-establishes the connection without full reset.
// R7: Shared power mode uses one pin for enable and overcurrent of all ports.
// R8: Overcurrent and upstream sense levels are synchronised before any decision.
package hpp_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] HPP_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] HPP_ADDR_STATUS = 8'h04;
    localparam logic [7:0] HPP_ADDR_EVENT  = 8'h08;
    localparam logic [7:0] HPP_ADDR_MASK   = 8'h0C;

    // Control fields: [0] port5 enable, [1] port6 enable, [2] shared power mode.
    localparam int HPP_CTRL_P5_EN  = 0;
    localparam int HPP_CTRL_P6_EN  = 1;
    localparam int HPP_CTRL_SHARED = 2;
    localparam logic [2:0] HPP_CTRL_RST = 3'h0;

    // Event fields: [0] port5 overcurrent, [1] port6 overcurrent, [2] upstream up, [3] upstream down.
    localparam int HPP_EV_OC5  = 0;
    localparam int HPP_EV_OC6  = 1;
    localparam int HPP_EV_UP   = 2;
    localparam int HPP_EV_DOWN = 3;
    localparam logic [3:0] HPP_EV_RST   = 4'h0;
    localparam logic [3:0] HPP_MASK_RST = 4'h0;

    localparam logic [1:0] HPP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] HPP_RESP_SLVERR = 2'h2;

    // Synchroniser depth.
    localparam int HPP_SYNC_STAGES = 2;

endpackage : hpp_pkg

// ---- core/hpp_sync.sv ----
// Two-flop level synchroniser for pin inputs.
`timescale 1ns/10ps
module hpp_sync
    import hpp_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } hpp_sync_state_t;

    hpp_sync_state_t state_ff;
    hpp_sync_state_t nxt_state;

    // The first stage feeds only the second stage.
    always_comb begin
        nxt_state.meta   = async_in; // R8
        nxt_state.stable = state_ff.meta; // R8
    end

    // Reset value is high: an idle pulled-up pin must not read as an alarm.
    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= '1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sync_out = state_ff.stable;
endmodule : hpp_sync

// ---- core/hpp_top.sv ----
// Port power control, overcurrent sense and upstream power sense with AXI4-Lite registers.
`timescale 1ns/10ps
module hpp_top
    import hpp_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Host port disable command, one bit per port (bit0 port5, bit1 port6).
    input  wire logic [1:0]  host_port_off,
    // Open-drain power control pins.
    input  wire logic        port5_power_ctl_in,
    output logic             port5_power_ctl_out,
    output logic             port5_power_ctl_oe,
    output logic             port5_pullup_en,
    input  wire logic        port6_power_ctl_in,
    output logic             port6_power_ctl_out,
    output logic             port6_power_ctl_oe,
    output logic             port6_pullup_en,
    // Shared power control pin, used in shared mode.
    input  wire logic        shared_power_control_in,
    output logic             shared_power_control_out,
    output logic             shared_power_control_oe,
    output logic             shared_pullup_en,
    input  wire logic        upstream_power_sense,
    output logic             upstream_connected,
    output logic             irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [2:0]  ctrl;
        logic [3:0]  events;
        logic [3:0]  mask;
        logic [1:0]  oc;
        logic        up;
        logic [2:0]  oe;
        logic [5:0]  oe_d;
        logic        irq;
    } hpp_state_t;

    hpp_state_t state_ff;
    hpp_state_t nxt_state;

    logic [2:0] pins_sync;
    logic [1:0] en_eff;
    logic       shared_en;
    logic [1:0] oc_now;
    logic [2:0] released;
    logic [3:0] ev_set;
    logic [3:0] ev_clr;
    logic       wr_fire;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == HPP_ADDR_CTRL) || (a == HPP_ADDR_STATUS) ||
                  (a == HPP_ADDR_EVENT) || (a == HPP_ADDR_MASK);
    endfunction : addr_ok

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    hpp_sync #(
        .WIDTH (3)
    ) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in ({shared_power_control_in, port6_power_ctl_in, port5_power_ctl_in}), // R8
        .sync_out (pins_sync)
    );

    logic up_sync_n;
    // The sense rides inverted because the synchroniser resets high and no power must read as idle.
    hpp_sync #(
        .WIDTH (1)
    ) u_sync_up (
        .clock    (clock),
        .rst      (rst),
        .async_in (~upstream_power_sense), // R8
        .sync_out (up_sync_n)
    );

    // ----------------------------------------------------------------
    // Port logic
    // ----------------------------------------------------------------
    always_comb begin
        released  = ~(state_ff.oe | state_ff.oe_d[2:0] | state_ff.oe_d[5:3]);
        shared_en = state_ff.ctrl[HPP_CTRL_SHARED];
        en_eff    = state_ff.ctrl[HPP_CTRL_P6_EN:HPP_CTRL_P5_EN] & ~host_port_off; // R3
        // Overcurrent counts only once the pin has been released for three cycles, one more than the synchroniser depth.
        if (shared_en) begin
            oc_now = {2{(|en_eff) && released[2] && !pins_sync[2]}}; // R7 R2 R4
        end else begin
            oc_now[0] = en_eff[0] && released[0] && !pins_sync[0]; // R2 R4
            oc_now[1] = en_eff[1] && released[1] && !pins_sync[1]; // R2 R4
        end
        ev_set = {state_ff.up && up_sync_n, !state_ff.up && !up_sync_n, oc_now & ~state_ff.oc}; // R6
        wr_fire = state_ff.aw_got && state_ff.w_got && !state_ff.bvalid;
        ev_clr  = '0;
        if (wr_fire && state_ff.awaddr == HPP_ADDR_EVENT && state_ff.wstrb[0]) begin
            ev_clr = state_ff.wdata[3:0];
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.oc = oc_now;
        nxt_state.up = !up_sync_n; // R5 R6
        // Set wins over a same-cycle clear.
        nxt_state.events = (state_ff.events & ~ev_clr) | ev_set;
        if (shared_en) begin
            nxt_state.oe = {!(|en_eff), 2'b00}; // R7 R3
        end else begin
            nxt_state.oe = {1'b0, ~en_eff}; // R1 R3
        end
        nxt_state.oe_d = {state_ff.oe_d[2:0], state_ff.oe};
        nxt_state.irq = |(nxt_state.events & state_ff.mask);

        // Write channel: address and data accepted in either order.
        nxt_state.awready = !state_ff.aw_got && !state_ff.bvalid;
        nxt_state.wready  = !state_ff.w_got && !state_ff.bvalid;
        if (s_axi_awvalid && state_ff.awready) begin
            nxt_state.aw_got  = 1'b1;
            nxt_state.awaddr  = s_axi_awaddr;
            nxt_state.awready = 1'b0;
        end
        if (s_axi_wvalid && state_ff.wready) begin
            nxt_state.w_got  = 1'b1;
            nxt_state.wdata  = s_axi_wdata;
            nxt_state.wstrb  = s_axi_wstrb;
            nxt_state.wready = 1'b0;
        end
        if (wr_fire) begin
            nxt_state.bvalid = 1'b1;
            nxt_state.bresp  = addr_ok(state_ff.awaddr) ? HPP_RESP_OKAY : HPP_RESP_SLVERR;
            if (state_ff.wstrb[0]) begin
                unique case (state_ff.awaddr)
                    HPP_ADDR_CTRL: begin
                        nxt_state.ctrl = state_ff.wdata[2:0];
                    end
                    HPP_ADDR_MASK: begin
                        nxt_state.mask = state_ff.wdata[3:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (state_ff.bvalid && s_axi_bready) begin
            nxt_state.bvalid  = 1'b0;
            nxt_state.aw_got  = 1'b0;
            nxt_state.w_got   = 1'b0;
            nxt_state.awready = 1'b1;
            nxt_state.wready  = 1'b1;
        end

        // Read channel.
        nxt_state.arready = !state_ff.rvalid && !(s_axi_arvalid && state_ff.arready);
        if (s_axi_arvalid && state_ff.arready) begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rresp  = addr_ok(s_axi_araddr) ? HPP_RESP_OKAY : HPP_RESP_SLVERR;
            unique case (s_axi_araddr)
                HPP_ADDR_CTRL:   nxt_state.rdata = {29'h0, state_ff.ctrl};
                HPP_ADDR_STATUS: nxt_state.rdata = {27'h0, en_eff, state_ff.up, state_ff.oc}; // R5
                HPP_ADDR_EVENT:  nxt_state.rdata = {28'h0, state_ff.events};
                HPP_ADDR_MASK:   nxt_state.rdata = {28'h0, state_ff.mask};
                default:         nxt_state.rdata = 32'h0;
            endcase
        end
        if (state_ff.rvalid && s_axi_rready) begin
            nxt_state.rvalid  = 1'b0;
            nxt_state.arready = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff        <= '0;
            state_ff.ctrl   <= HPP_CTRL_RST;
            state_ff.events <= HPP_EV_RST;
            state_ff.mask   <= HPP_MASK_RST;
            state_ff.oe     <= 3'h7;
            state_ff.oe_d   <= '1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = state_ff.awready;
    assign s_axi_wready  = state_ff.wready;
    assign s_axi_bvalid  = state_ff.bvalid;
    assign s_axi_bresp   = state_ff.bresp;
    assign s_axi_arready = state_ff.arready;
    assign s_axi_rvalid  = state_ff.rvalid;
    assign s_axi_rdata   = state_ff.rdata;
    assign s_axi_rresp   = state_ff.rresp;
    // Pins drive only low; pull-up is on whenever the pin is released.
    assign port5_power_ctl_out      = 1'b0; // R3
    assign port6_power_ctl_out      = 1'b0; // R3
    assign shared_power_control_out = 1'b0; // R3
    assign port5_power_ctl_oe       = state_ff.oe[0];
    assign port6_power_ctl_oe       = state_ff.oe[1];
    assign shared_power_control_oe  = state_ff.oe[2];
    assign port5_pullup_en          = !state_ff.oe[0]; // R1
    assign port6_pullup_en          = !state_ff.oe[1]; // R1
    assign shared_pullup_en         = !state_ff.oe[2]; // R1 R7
    assign upstream_connected       = state_ff.up; // R5
    assign irq                      = state_ff.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_disable_drives;
        @(posedge clock) disable iff (rst)
        (!shared_en && !en_eff[0]) |=> port5_power_ctl_oe;
    endproperty
    a_disable_drives: assert property (p_disable_drives) else $error("disabled port5 not driven"); // R3

    property p_enable_release;
        @(posedge clock) disable iff (rst)
        (!shared_en && en_eff[1]) |=> (!port6_power_ctl_oe && port6_pullup_en);
    endproperty
    a_enable_release: assert property (p_enable_release) else $error("enabled port6 not released"); // R1

    property p_oc_detect;
        @(posedge clock) disable iff (rst)
        (!shared_en && en_eff[0] && released[0] && !pins_sync[0]) |=> state_ff.oc[0];
    endproperty
    a_oc_detect: assert property (p_oc_detect) else $error("overcurrent missed"); // R2

    property p_oc_low_only;
        @(posedge clock) disable iff (rst)
        state_ff.oc[1] |-> $past(!pins_sync[1] || pins_sync[2] == 1'b0);
    endproperty
    a_oc_low_only: assert property (p_oc_low_only) else $error("overcurrent without low pin"); // R4

    property p_up_follow;
        @(posedge clock) disable iff (rst)
        $rose(upstream_power_sense) ##1 upstream_power_sense [*2] |=> upstream_connected;
    endproperty
    a_up_follow: assert property (p_up_follow) else $error("upstream not connected"); // R5

    property p_renegotiate;
        @(posedge clock) disable iff (rst)
        $fell(upstream_connected) |-> ##[1:2] state_ff.events[HPP_EV_DOWN];
    endproperty
    a_renegotiate: assert property (p_renegotiate) else $error("drop not flagged"); // R6

    property p_shared_pin;
        @(posedge clock) disable iff (rst)
        shared_en |=> (!port5_power_ctl_oe && !port6_power_ctl_oe);
    endproperty
    a_shared_pin: assert property (p_shared_pin) else $error("per-port pin driven in shared mode"); // R7

    property p_sync_delay;
        @(posedge clock) disable iff (rst)
        $changed(upstream_power_sense) |=> $stable(up_sync_n);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sense passed too fast"); // R8

endmodule : hpp_top

// ---- bench/hpp_partner.sv ----
// Model of the external power switches, current monitors and upstream host.
`timescale 1ns/10ps
module hpp_partner (
    input  wire logic       port5_power_ctl_oe,
    input  wire logic       port5_power_ctl_out,
    input  wire logic       port5_pullup_en,
    input  wire logic       port6_power_ctl_oe,
    input  wire logic       port6_power_ctl_out,
    input  wire logic       port6_pullup_en,
    input  wire logic       shared_power_control_oe,
    input  wire logic       shared_power_control_out,
    input  wire logic       shared_pullup_en,
    input  wire logic [2:0] oc_req,
    input  wire logic       vbus_req,
    output logic            port5_power_ctl_in,
    output logic            port6_power_ctl_in,
    output logic            shared_power_control_in,
    output logic            upstream_power_sense
);
    // A released pin without pull-up falls to the board pull-down, so it never reads as powered.
    function automatic logic lvl(input logic oe, input logic dout, input logic pu, input logic oc);
        return oe ? dout : (oc ? 1'b0 : pu);
    endfunction : lvl

    assign port5_power_ctl_in      = lvl(port5_power_ctl_oe, port5_power_ctl_out, port5_pullup_en, oc_req[0]);
    assign port6_power_ctl_in      = lvl(port6_power_ctl_oe, port6_power_ctl_out, port6_pullup_en, oc_req[1]);
    assign shared_power_control_in = lvl(shared_power_control_oe, shared_power_control_out, shared_pullup_en,
                                         oc_req[2]);
    assign upstream_power_sense    = vbus_req;
endmodule : hpp_partner

// ---- bench/tb_top.sv ----
// Self-checking testbench for the hub port power and upstream sense block.
`timescale 1ns/10ps
module tb_top;
    import hpp_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, vbus_req = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs, host_port_off = 2'h0;
    logic [31:0] s_axi_rdata;
    logic [2:0]  oc_req = 3'h0;
    logic        port5_power_ctl_in, port5_power_ctl_out, port5_power_ctl_oe, port5_pullup_en;
    logic        port6_power_ctl_in, port6_power_ctl_out, port6_power_ctl_oe, port6_pullup_en;
    logic        shared_power_control_in, shared_power_control_out, shared_power_control_oe, shared_pullup_en;
    logic        upstream_power_sense, upstream_connected;
    int          fails = 0, total_checks = 0, cycles = 0;

    always #5 clock = ~clock;

    hpp_top i_dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_port_off,
        .port5_power_ctl_in, .port5_power_ctl_out, .port5_power_ctl_oe, .port5_pullup_en,
        .port6_power_ctl_in, .port6_power_ctl_out, .port6_power_ctl_oe, .port6_pullup_en,
        .shared_power_control_in, .shared_power_control_out, .shared_power_control_oe, .shared_pullup_en,
        .upstream_power_sense, .upstream_connected, .irq);

    hpp_partner i_far (.port5_power_ctl_oe, .port5_power_ctl_out, .port5_pullup_en, .port6_power_ctl_oe,
        .port6_power_ctl_out, .port6_pullup_en, .shared_power_control_oe, .shared_power_control_out,
        .shared_pullup_en, .oc_req, .vbus_req, .port5_power_ctl_in, .port6_power_ctl_in,
        .shared_power_control_in, .upstream_power_sense);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // Outputs are read just after an edge, so they show what the previous edge settled.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw, w;
        aw = 0;
        w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clock);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask : rdr

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        rdr(a);
        chk(nm, e, rd);
    endtask : rchk

    function automatic logic [31:0] pins();
        return 32'({port5_power_ctl_oe, port5_pullup_en, port6_power_ctl_oe, port6_pullup_en});
    endfunction : pins

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("pins", 32'hA, pins());
        chk("outs", 32'h0, 32'({port5_power_ctl_out, port6_power_ctl_out, shared_power_control_out}));
        chk("conn irq", 32'h0, 32'({upstream_connected, irq}));
        rchk("ctrl", HPP_ADDR_CTRL, 32'h0);
        rchk("status", HPP_ADDR_STATUS, 32'h0);
        rchk("event", HPP_ADDR_EVENT, 32'h0);
        rchk("mask", HPP_ADDR_MASK, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_enable();
        wr(HPP_ADDR_CTRL, 32'h1);
        tick(2);
        chk("pins p5", 32'h6, pins());
        rchk("status p5", HPP_ADDR_STATUS, 32'h08);
        host_port_off <= 2'h1;
        tick(3);
        chk("pins host off", 32'hA, pins());
        host_port_off <= 2'h0;
        wr(HPP_ADDR_CTRL, 32'h3);
        tick(2);
        chk("pins both", 32'h5, pins());
        host_port_off <= 2'h2;
        tick(3);
        chk("pins host off p6", 32'h6, pins());
        host_port_off <= 2'h0;
        tick(4);
        rchk("event no false oc", HPP_ADDR_EVENT, 32'h0);
        $display("test enable done");
    endtask : t_enable

    task automatic t_oc();
        wr(HPP_ADDR_EVENT, 32'hF);
        wr(HPP_ADDR_MASK, 32'h3);
        oc_req <= 3'h1;
        tick(5);
        rchk("status oc5", HPP_ADDR_STATUS, 32'h19);
        rchk("event oc5", HPP_ADDR_EVENT, 32'h1);
        chk("irq on", 32'h1, 32'(irq));
        wr(HPP_ADDR_MASK, 32'h0);
        tick(2);
        chk("irq masked", 32'h0, 32'(irq));
        oc_req <= 3'h0;
        wr(HPP_ADDR_EVENT, 32'h1);
        rchk("event clr", HPP_ADDR_EVENT, 32'h0);
        wr(HPP_ADDR_CTRL, 32'h1);
        oc_req <= 3'h2;
        tick(5);
        rchk("status driven low", HPP_ADDR_STATUS, 32'h08);
        rchk("event driven low", HPP_ADDR_EVENT, 32'h0);
        oc_req <= 3'h0;
        $display("test overcurrent done");
    endtask : t_oc

    task automatic t_shared();
        wr(HPP_ADDR_CTRL, 32'h4);
        tick(2);
        chk("shared off", 32'h2, 32'({shared_power_control_oe, shared_pullup_en}));
        wr(HPP_ADDR_CTRL, 32'h5);
        tick(2);
        chk("shared on", 32'h1, 32'({shared_power_control_oe, shared_pullup_en}));
        oc_req <= 3'h4;
        tick(5);
        rdr(HPP_ADDR_STATUS);
        chk("shared oc", 32'h3, 32'(rd[1:0]));
        oc_req <= 3'h0;
        wr(HPP_ADDR_CTRL, 32'h0);
        $display("test shared done");
    endtask : t_shared

    task automatic t_upstream();
        wr(HPP_ADDR_EVENT, 32'hF);
        wr(HPP_ADDR_MASK, 32'hC);
        vbus_req <= 1'b1;
        tick(3);
        chk("conn sync", 32'h0, 32'(upstream_connected));
        tick(1);
        chk("conn up", 32'h1, 32'(upstream_connected));
        rchk("event up", HPP_ADDR_EVENT, 32'h4);
        chk("irq up", 32'h1, 32'(irq));
        wr(HPP_ADDR_EVENT, 32'h4);
        vbus_req <= 1'b0;
        tick(5);
        chk("conn down", 32'h0, 32'(upstream_connected));
        rchk("event down", HPP_ADDR_EVENT, 32'h8);
        vbus_req <= 1'b1;
        tick(5);
        chk("conn again", 32'h1, 32'(upstream_connected));
        rchk("status up", HPP_ADDR_STATUS, 32'h04);
        $display("test upstream done");
    endtask : t_upstream

    task automatic t_unmapped();
        rdr(8'h10);
        chk("rd resp", 32'(HPP_RESP_SLVERR), 32'(rs));
        chk("rd data", 32'h0, rd);
        wr(8'h10, 32'hFFFF_FFFF);
        chk("wr resp", 32'(HPP_RESP_SLVERR), 32'(rs));
        s_axi_wstrb <= 4'h0;
        wr(HPP_ADDR_CTRL, 32'h1);
        chk("strb resp", 32'(HPP_RESP_OKAY), 32'(rs));
        s_axi_wstrb <= 4'hF;
        rchk("ctrl kept", HPP_ADDR_CTRL, 32'h0);
        $display("test unmapped done");
    endtask : t_unmapped

    initial begin
        tick(20);
        rst <= 1'b0;
        tick(1);
        t_reset();
        t_enable();
        t_oc();
        t_shared();
        t_upstream();
        t_unmapped();
        end_sim();
    end
endmodule : tb_top
